/* rtl/ahtf_bank.sv */
`timescale 1ns/1ps
`default_nettype none

// Task-file byte bank: host and firmware write, read data registered
module ahtf_bank #(
	parameter int DEPTH = 6,
	parameter int AW    = 3
) (
	input  wire logic          i_clk_sys,
	input  wire logic          i_rst_b,
	input  wire logic          i_host_wr,
	input  wire logic [AW-1:0] i_host_idx,
	input  wire logic [7:0]    i_host_wdata,
	input  wire logic          i_fw_wr,
	input  wire logic [AW-1:0] i_fw_idx,
	input  wire logic [7:0]    i_fw_wdata,
	input  wire logic [AW-1:0] i_rd_idx,
	output logic      [7:0]    o_rd_data
);

	logic [7:0] mem_reg [DEPTH];

	// ------------------------------------------------------------
	// Storage; host write wins a same-slot collision
	// ------------------------------------------------------------
	for (genvar g = 0; g < DEPTH; g++) begin : g_slot
		always_ff @(posedge i_clk_sys) begin
			if (!i_rst_b) begin
				mem_reg[g] <= 8'h00;
			end else if (i_host_wr && i_host_idx == AW'(g)) begin
				mem_reg[g] <= i_host_wdata;
			end else if (i_fw_wr && i_fw_idx == AW'(g)) begin
				mem_reg[g] <= i_fw_wdata;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_rd_data <= 8'h00;
		end else if (int'(i_rd_idx) < DEPTH) begin
			o_rd_data <= mem_reg[i_rd_idx];
		end else begin
			o_rd_data <= 8'h00;
		end
	end

endmodule : ahtf_bank

`default_nettype wire

/* rtl/ahtf_pkg.sv */
package ahtf_pkg;

	// Host bus pins as sampled
	typedef struct packed {
		logic        cs1_b;
		logic        cs2_b;
		logic [2:0]  da;
		logic        hrd_b;
		logic        hwr_b;
		logic [15:0] hd;
	} ahtf_bus_t;

	// Decoded task-file register
	typedef enum logic [3:0] {
		AHTF_R_NONE,
		AHTF_R_DATA,
		AHTF_R_FEAT_ERR,
		AHTF_R_IREASON,
		AHTF_R_SECT,
		AHTF_R_BCL,
		AHTF_R_BCH,
		AHTF_R_DRVSEL,
		AHTF_R_CMD_STAT,
		AHTF_R_DCTL_ALT,
		AHTF_R_DRVADDR
	} ahtf_reg_t;

	typedef enum logic [1:0] {
		AHTF_ST_IDLE,
		AHTF_ST_READ,
		AHTF_ST_WRITE
	} ahtf_state_t;

endpackage : ahtf_pkg

/* rtl/ahtf_regs.svh */
`ifndef AHTF_REGS_SVH
`define AHTF_REGS_SVH

// ------------------------------------------------------------
// Command block addresses (chip select 1 active)
// ------------------------------------------------------------
`define AHTF_DA_DATA     3'h0
`define AHTF_DA_FEAT_ERR 3'h1
`define AHTF_DA_IREASON  3'h2
`define AHTF_DA_SECT     3'h3
`define AHTF_DA_BCL      3'h4
`define AHTF_DA_BCH      3'h5
`define AHTF_DA_DRVSEL   3'h6
`define AHTF_DA_CMD_STAT 3'h7
// ------------------------------------------------------------
// Control block addresses (chip select 2 active)
// ------------------------------------------------------------
`define AHTF_DA_DCTL_ALT 3'h6
`define AHTF_DA_DRVADDR  3'h7

// ------------------------------------------------------------
// Bank slot of the drive address byte
// ------------------------------------------------------------
`define AHTF_IDX_DRVADDR 3'h0

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define AHTF_BUSY_BIT    7
`define AHTF_DRIVE_BIT   4
`define AHTF_SRST_BIT    2
`define AHTF_NIEN_BIT    1
`define AHTF_FLOAT_BIT   7

// ------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------
`define AHTF_DIAG_CMD    8'h90
`define AHTF_DRVSEL_ONES 8'he0
`define AHTF_DRVSEL_RST  8'he0
`define AHTF_DCTL_ONES   8'h08
`define AHTF_DCTL_MASK   8'h06
`define AHTF_DCTL_RST    8'h00
`define AHTF_CMD_RST     8'h00

`endif

/* rtl/ahtf_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ahtf_regs.svh"

// Contract
// [R01] Sixteen-bit data port, host writes and reads
// [R02] Host uses data port only during transfer; code accepts data port access at any time
// [R03] Selected while drive bit equals remote bit
// [R04] Interrupt pin driven only enabled and selected
// [R05] Command write while selected interrupts firmware
// [R06] Diagnostic command always interrupts and sets busy
// [R07] Any command write clears host interrupt
// [R08] Busy set by command, diagnostic, reset
// [R09] Alternate status mirrors status, keeps interrupt
// [R10] Software reset bit interrupts firmware, sets busy
// [R11] Drive address read floats data bit seven
// [R12] Two selects, three address lines decode
// [R13] Main status read clears host interrupt
module ahtf_top (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	input  wire logic        i_cs1_b,
	input  wire logic        i_cs2_b,
	input  wire logic [2:0]  i_da,
	input  wire logic        i_hrd_b,
	input  wire logic        i_hwr_b,
	input  wire logic [15:0] i_hd,
	output logic      [15:0] o_hd,
	output logic      [15:0] o_hd_oe_b,
	output logic             o_intrq,
	output logic             o_intrq_oe_b,
	input  wire logic        i_remote_drive_bit,
	input  wire logic [6:0]  i_fw_status,
	input  wire logic        i_busy_clear,
	input  wire logic        i_host_irq_set,
	input  wire logic        i_fw_wr,
	input  wire logic [2:0]  i_fw_idx,
	input  wire logic [7:0]  i_fw_wdata,
	input  wire logic [15:0] i_data_rd,
	output logic             o_data_rd_ack,
	output logic             o_data_wr_valid,
	output logic      [15:0] o_data_wr,
	output logic             o_command_irq,
	output logic             o_soft_reset_irq,
	output logic      [7:0]  o_command_code,
	output logic      [7:0]  o_features,
	output logic             o_selected,
	output logic             o_busy
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic ahtf_pkg::ahtf_reg_t decode(
		input logic       cs1_b,
		input logic       cs2_b,
		input logic [2:0] da
	);
		decode = ahtf_pkg::AHTF_R_NONE;
		if (!cs1_b && cs2_b) begin // R12
			unique case (da)
				`AHTF_DA_DATA:     decode = ahtf_pkg::AHTF_R_DATA;
				`AHTF_DA_FEAT_ERR: decode = ahtf_pkg::AHTF_R_FEAT_ERR;
				`AHTF_DA_IREASON:  decode = ahtf_pkg::AHTF_R_IREASON;
				`AHTF_DA_SECT:     decode = ahtf_pkg::AHTF_R_SECT;
				`AHTF_DA_BCL:      decode = ahtf_pkg::AHTF_R_BCL;
				`AHTF_DA_BCH:      decode = ahtf_pkg::AHTF_R_BCH;
				`AHTF_DA_DRVSEL:   decode = ahtf_pkg::AHTF_R_DRVSEL;
				`AHTF_DA_CMD_STAT: decode = ahtf_pkg::AHTF_R_CMD_STAT;
				default:           decode = ahtf_pkg::AHTF_R_NONE;
			endcase
		end else if (cs1_b && !cs2_b) begin // R12
			if (da == `AHTF_DA_DCTL_ALT) begin
				decode = ahtf_pkg::AHTF_R_DCTL_ALT;
			end else if (da == `AHTF_DA_DRVADDR) begin
				decode = ahtf_pkg::AHTF_R_DRVADDR;
			end
		end
	endfunction : decode

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	ahtf_pkg::ahtf_bus_t sync1_reg;
	ahtf_pkg::ahtf_bus_t sync2_reg;
	ahtf_pkg::ahtf_bus_t prev_reg;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
			prev_reg  <= '1;
		end else begin
			sync1_reg <= {i_cs1_b, i_cs2_b, i_da, i_hrd_b, i_hwr_b, i_hd};
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	logic rd_fall;
	logic rd_rise;
	logic wr_fall;
	logic wr_rise;
	assign rd_fall = prev_reg.hrd_b && !sync2_reg.hrd_b;
	assign rd_rise = !prev_reg.hrd_b && sync2_reg.hrd_b;
	assign wr_fall = prev_reg.hwr_b && !sync2_reg.hwr_b;
	assign wr_rise = !prev_reg.hwr_b && sync2_reg.hwr_b;

	// ------------------------------------------------------------
	// Host cycle sequencer
	// ------------------------------------------------------------
	ahtf_pkg::ahtf_state_t state_reg;
	ahtf_pkg::ahtf_reg_t   sel_reg;
	ahtf_pkg::ahtf_reg_t   live_sel;
	assign live_sel = decode(sync2_reg.cs1_b, sync2_reg.cs2_b, sync2_reg.da);

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			state_reg <= ahtf_pkg::AHTF_ST_IDLE;
			sel_reg   <= ahtf_pkg::AHTF_R_NONE;
		end else begin
			unique case (state_reg)
				ahtf_pkg::AHTF_ST_IDLE: begin
					if (rd_fall) begin
						state_reg <= ahtf_pkg::AHTF_ST_READ;
						sel_reg   <= live_sel;
					end else if (wr_fall) begin
						state_reg <= ahtf_pkg::AHTF_ST_WRITE;
						sel_reg   <= live_sel;
					end
				end
				ahtf_pkg::AHTF_ST_READ: begin
					if (rd_rise) begin
						state_reg <= ahtf_pkg::AHTF_ST_IDLE;
					end
				end
				ahtf_pkg::AHTF_ST_WRITE: begin
					if (wr_rise) begin
						state_reg <= ahtf_pkg::AHTF_ST_IDLE;
					end
				end
			endcase
		end
	end

	logic rd_end;
	logic wr_end;
	assign rd_end = state_reg == ahtf_pkg::AHTF_ST_READ && rd_rise;
	assign wr_end = state_reg == ahtf_pkg::AHTF_ST_WRITE && wr_rise;

	logic wr_data;
	logic wr_cmd;
	logic wr_dctl;
	logic rd_stat;
	assign wr_data = wr_end && sel_reg == ahtf_pkg::AHTF_R_DATA;
	assign wr_cmd  = wr_end && sel_reg == ahtf_pkg::AHTF_R_CMD_STAT;
	assign wr_dctl = wr_end && sel_reg == ahtf_pkg::AHTF_R_DCTL_ALT;
	assign rd_stat = rd_end && sel_reg == ahtf_pkg::AHTF_R_CMD_STAT;

	// ------------------------------------------------------------
	// Host-written registers
	// ------------------------------------------------------------
	logic [7:0] drvsel_reg;
	logic [7:0] dctl_reg;
	logic       selected;
	logic       cmd_take;
	logic       srst_rise;
	assign selected  = drvsel_reg[`AHTF_DRIVE_BIT] == i_remote_drive_bit; // R03
	assign cmd_take  = wr_cmd && (selected
		|| sync2_reg.hd[7:0] == `AHTF_DIAG_CMD); // R05 R06
	assign srst_rise = wr_dctl && sync2_reg.hd[`AHTF_SRST_BIT]
		&& !dctl_reg[`AHTF_SRST_BIT]; // R10

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			drvsel_reg <= `AHTF_DRVSEL_RST;
		end else if (wr_end && sel_reg == ahtf_pkg::AHTF_R_DRVSEL) begin
			drvsel_reg <= sync2_reg.hd[7:0] | `AHTF_DRVSEL_ONES;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			dctl_reg <= `AHTF_DCTL_RST;
		end else if (wr_dctl) begin
			dctl_reg <= sync2_reg.hd[7:0] & `AHTF_DCTL_MASK;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_features <= 8'h00;
		end else if (wr_end && sel_reg == ahtf_pkg::AHTF_R_FEAT_ERR) begin
			o_features <= sync2_reg.hd[7:0];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_command_code <= `AHTF_CMD_RST;
			o_command_irq  <= 1'b0;
		end else begin
			o_command_irq <= cmd_take; // R05 R06
			if (cmd_take) begin
				o_command_code <= sync2_reg.hd[7:0];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_soft_reset_irq <= 1'b0;
		end else begin
			o_soft_reset_irq <= srst_rise; // R10
		end
	end

	// ------------------------------------------------------------
	// Busy flag and host interrupt; set wins over clear
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_busy <= 1'b1; // R08
		end else if (cmd_take || srst_rise) begin
			o_busy <= 1'b1; // R08
		end else if (i_busy_clear) begin
			o_busy <= 1'b0;
		end
	end

	logic irq_pend_reg;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			irq_pend_reg <= 1'b0;
		end else if (i_host_irq_set && selected) begin
			irq_pend_reg <= 1'b1; // R03
		end else if (wr_cmd || rd_stat) begin
			irq_pend_reg <= 1'b0; // R07 R13
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_intrq      <= 1'b0;
			o_intrq_oe_b <= 1'b1;
			o_selected   <= 1'b0;
		end else begin
			o_intrq      <= irq_pend_reg;
			o_intrq_oe_b <= dctl_reg[`AHTF_NIEN_BIT] || !selected; // R04
			o_selected   <= selected;
		end
	end

	// ------------------------------------------------------------
	// Data port
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_data_wr_valid <= 1'b0;
			o_data_wr       <= 16'h0000;
			o_data_rd_ack   <= 1'b0;
		end else begin
			o_data_wr_valid <= wr_data; // R01 R02
			o_data_rd_ack   <= rd_end && sel_reg == ahtf_pkg::AHTF_R_DATA;
			if (wr_data) begin
				o_data_wr <= sync2_reg.hd; // R01
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [2:0] bank_rd_idx;
	logic [7:0] bank_rd;
	logic [7:0] status;
	logic       bank_host_wr;
	assign bank_rd_idx = live_sel == ahtf_pkg::AHTF_R_DRVADDR ?
		`AHTF_IDX_DRVADDR : sync2_reg.da;
	assign status = {o_busy, i_fw_status};
	assign bank_host_wr = wr_end && (sel_reg == ahtf_pkg::AHTF_R_IREASON
		|| sel_reg == ahtf_pkg::AHTF_R_SECT
		|| sel_reg == ahtf_pkg::AHTF_R_BCL
		|| sel_reg == ahtf_pkg::AHTF_R_BCH);

	ahtf_bank #(
		.DEPTH (6),
		.AW    (3)
	) u_bank (
		.i_clk_sys    (i_clk_sys),
		.i_rst_b      (i_rst_b),
		.i_host_wr    (bank_host_wr),
		.i_host_idx   (sync2_reg.da),
		.i_host_wdata (sync2_reg.hd[7:0]),
		.i_fw_wr      (i_fw_wr),
		.i_fw_idx     (i_fw_idx),
		.i_fw_wdata   (i_fw_wdata),
		.i_rd_idx     (bank_rd_idx),
		.o_rd_data    (bank_rd)
	);

	logic [15:0] rd_next;
	logic [15:0] oe_b_next;
	always_comb begin
		rd_next   = {8'h00, bank_rd};
		oe_b_next = 16'hffff;
		if (state_reg == ahtf_pkg::AHTF_ST_READ) begin
			oe_b_next = 16'hff00;
			unique case (sel_reg)
				ahtf_pkg::AHTF_R_DATA: begin
					rd_next   = i_data_rd; // R01
					oe_b_next = 16'h0000;
				end
				ahtf_pkg::AHTF_R_DRVSEL:   rd_next = {8'h00, drvsel_reg};
				ahtf_pkg::AHTF_R_CMD_STAT: rd_next = {8'h00, status};
				ahtf_pkg::AHTF_R_DCTL_ALT: rd_next = {8'h00, status}; // R09
				ahtf_pkg::AHTF_R_DRVADDR: begin
					oe_b_next[`AHTF_FLOAT_BIT] = 1'b1; // R11
				end
				ahtf_pkg::AHTF_R_NONE:     oe_b_next = 16'hffff;
				default:                   rd_next = {8'h00, bank_rd};
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_hd      <= 16'h0000;
			o_hd_oe_b <= 16'hffff;
		end else begin
			o_hd      <= rd_next;
			o_hd_oe_b <= oe_b_next;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	a_cmd_irq_pulse: assert property (cmd_take |=> o_command_irq) // R05
		else $error("command interrupt missing");
	a_diag_busy: assert property (wr_cmd
		&& sync2_reg.hd[7:0] == `AHTF_DIAG_CMD |=> o_busy && o_command_irq) // R06
		else $error("diagnostic did not set busy");
	a_unsel_quiet: assert property (wr_cmd && !selected
		&& sync2_reg.hd[7:0] != `AHTF_DIAG_CMD |=> !o_command_irq) // R03
		else $error("unselected drive took command");
	a_cmd_clr_irq: assert property (wr_cmd && !(i_host_irq_set && selected)
		|=> ##1 !o_intrq) // R07
		else $error("command write left interrupt set");
	a_stat_clr_irq: assert property (rd_stat && !(i_host_irq_set && selected)
		|=> ##1 !o_intrq) // R13
		else $error("status read left interrupt set");
	a_alt_keep_irq: assert property (rd_end
		&& sel_reg == ahtf_pkg::AHTF_R_DCTL_ALT && irq_pend_reg
		|=> irq_pend_reg) // R09
		else $error("alternate status read cleared interrupt");
	a_pin_float: assert property (dctl_reg[`AHTF_NIEN_BIT] || !selected
		|=> o_intrq_oe_b) // R04
		else $error("interrupt pin driven while disabled");
	a_srst_busy: assert property (srst_rise
		|=> o_soft_reset_irq && o_busy) // R10
		else $error("soft reset did not set busy");
	a_addr_float: assert property (state_reg == ahtf_pkg::AHTF_ST_READ
		&& sel_reg == ahtf_pkg::AHTF_R_DRVADDR
		|=> o_hd_oe_b[`AHTF_FLOAT_BIT]) // R11
		else $error("drive address bit seven driven");
	a_data_word: assert property (wr_data
		|=> o_data_wr_valid && o_data_wr == $past(sync2_reg.hd)) // R01
		else $error("data word not passed");
	a_busy_reset: assert property ($rose(i_rst_b) |-> o_busy) // R08
		else $error("busy not set by reset");

	c_cmd_write: cover property (cmd_take ##1 o_command_irq);
	c_data_read: cover property (o_data_rd_ack);
	c_srst: cover property (o_soft_reset_irq);
	c_irq_driven: cover property (o_intrq && !o_intrq_oe_b);

endmodule : ahtf_top

`default_nettype wire

/* tb/ahtf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host adapter driving the task-file bus
// ------------------------------------------------------------
module ahtf_host_model (
	input  wire logic        i_clk_sys,
	input  wire logic [15:0] i_hd_dev,
	input  wire logic [15:0] i_hd_oe_b,
	output logic             o_cs1_b,
	output logic             o_cs2_b,
	output logic      [2:0]  o_da,
	output logic             o_hrd_b,
	output logic             o_hwr_b,
	output logic      [15:0] o_bus
);
	logic [15:0] drv_data;
	logic        drv_en;
	logic [15:0] last;

	// Undriven lines show the inverse of their last level
	assign o_bus = (~i_hd_oe_b & i_hd_dev)
		| (i_hd_oe_b & (drv_en ? drv_data : ~last));

	always @(posedge i_clk_sys) begin
		last <= o_bus;
	end

	initial begin
		o_cs1_b = 1'b1;
		o_cs2_b = 1'b1;
		o_da = 3'h0;
		o_hrd_b = 1'b1;
		o_hwr_b = 1'b1;
		drv_data = 16'h0000;
		drv_en = 1'b0;
		last = 16'h0000;
	end

	// One strobe cycle; c2 picks the control block
	task automatic xfer(input logic c2, input logic [2:0] a,
		input logic w, input logic [15:0] d,
		output logic [15:0] q, output logic [15:0] qoe);
		@(posedge i_clk_sys);
		o_cs1_b <= c2;
		o_cs2_b <= ~c2;
		o_da <= a;
		drv_data <= d;
		drv_en <= w;
		@(posedge i_clk_sys);
		if (w) begin
			o_hwr_b <= 1'b0;
		end else begin
			o_hrd_b <= 1'b0;
		end
		repeat (7) @(posedge i_clk_sys);
		q = o_bus;
		qoe = i_hd_oe_b;
		o_hwr_b <= 1'b1;
		o_hrd_b <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		o_cs1_b <= 1'b1;
		o_cs2_b <= 1'b1;
		drv_en <= 1'b0;
	endtask : xfer
endmodule : ahtf_host_model

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ahtf_regs.svh"

module tb_top;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cs1_b, cs2_b, hrd_b, hwr_b;
	logic [2:0]  da;
	logic [15:0] bus, o_hd, o_hd_oe_b, o_data_wr, rdv, roe;
	logic        o_intrq, o_intrq_oe_b, o_data_rd_ack, o_data_wr_valid;
	logic        o_command_irq, o_soft_reset_irq, o_selected, o_busy;
	logic [7:0]  o_command_code, o_features, fw_wdata;
	logic        remote = 1'b0, busy_clr = 1'b0, irq_set = 1'b0;
	logic        fw_wr = 1'b0;
	logic [2:0]  fw_idx = 3'h0;
	logic [15:0] data_rd = 16'h3c5a;
	int          failures = 0, check_count = 0;
	int          n_cmd = 0, n_srst = 0, n_wr = 0, n_rd = 0;

	always #5 clk = ~clk;
	initial fw_wdata = 8'h00;

	ahtf_host_model host (.i_clk_sys(clk), .i_hd_dev(o_hd),
		.i_hd_oe_b(o_hd_oe_b), .o_cs1_b(cs1_b), .o_cs2_b(cs2_b),
		.o_da(da), .o_hrd_b(hrd_b), .o_hwr_b(hwr_b), .o_bus(bus));

	ahtf_top DUT (.i_clk_sys(clk), .i_rst_b(rst_b), .i_cs1_b(cs1_b),
		.i_cs2_b(cs2_b), .i_da(da), .i_hrd_b(hrd_b), .i_hwr_b(hwr_b),
		.i_hd(bus), .o_hd(o_hd), .o_hd_oe_b(o_hd_oe_b),
		.o_intrq(o_intrq), .o_intrq_oe_b(o_intrq_oe_b),
		.i_remote_drive_bit(remote), .i_fw_status(7'h51),
		.i_busy_clear(busy_clr), .i_host_irq_set(irq_set),
		.i_fw_wr(fw_wr), .i_fw_idx(fw_idx), .i_fw_wdata(fw_wdata),
		.i_data_rd(data_rd), .o_data_rd_ack(o_data_rd_ack),
		.o_data_wr_valid(o_data_wr_valid), .o_data_wr(o_data_wr),
		.o_command_irq(o_command_irq),
		.o_soft_reset_irq(o_soft_reset_irq),
		.o_command_code(o_command_code), .o_features(o_features),
		.o_selected(o_selected), .o_busy(o_busy));

	// ------------------------------------------------------------
	// Pulse counters
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (o_command_irq === 1'b1) n_cmd++;
		if (o_soft_reset_irq === 1'b1) n_srst++;
		if (o_data_wr_valid === 1'b1) n_wr++;
		if (o_data_rd_ack === 1'b1) n_rd++;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic c2, input logic [2:0] a,
		input logic [15:0] d);
		host.xfer(c2, a, 1'b1, d, rdv, roe);
	endtask : wr

	task automatic rd(input logic c2, input logic [2:0] a);
		host.xfer(c2, a, 1'b0, 16'h0000, rdv, roe);
	endtask : rd

	task automatic pulse_fw(input logic sel);
		@(posedge clk);
		if (sel) irq_set <= 1'b1;
		else busy_clr <= 1'b1;
		@(posedge clk);
		irq_set <= 1'b0;
		busy_clr <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse_fw

	task automatic print_verdict;
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		chk("busy_rst", 16'h1, {15'h0, o_busy});
		rd(1'b0, `AHTF_DA_CMD_STAT);
		chk("status_rst", 16'h00d1, {8'h00, rdv[7:0]});
		rd(1'b0, `AHTF_DA_DRVSEL);
		chk("drvsel_rst", 16'h00e0, {8'h00, rdv[7:0]});
		chk("sel_rst", 16'h1, {15'h0, o_selected});
		// Data port written and read with no transfer set up first
		wr(1'b0, `AHTF_DA_DATA, 16'ha5c3);
		chk("data_wr", 16'ha5c3, o_data_wr);
		chk("n_wr", 16'h1, n_wr[15:0]);
		rd(1'b0, `AHTF_DA_DATA);
		chk("data_rd", 16'h3c5a, rdv);
		chk("data_oe", 16'h0000, roe);
		chk("n_rd", 16'h1, n_rd[15:0]);
		pulse_fw(1'b0);
		pulse_fw(1'b1);
		chk("intrq_on", 16'h1, {15'h0, o_intrq});
		chk("intrq_oe", 16'h0, {15'h0, o_intrq_oe_b});
		rd(1'b1, `AHTF_DA_DCTL_ALT);
		chk("alt", 16'h0051, {8'h00, rdv[7:0]});
		chk("alt_oe", 16'hff00, roe);
		chk("intrq_alt", 16'h1, {15'h0, o_intrq});
		rd(1'b0, `AHTF_DA_CMD_STAT);
		chk("stat", 16'h0051, {8'h00, rdv[7:0]});
		chk("intrq_stat", 16'h0, {15'h0, o_intrq});
		pulse_fw(1'b1);
		wr(1'b0, `AHTF_DA_CMD_STAT, 16'h00a0);
		chk("n_cmd_sel", 16'h1, n_cmd[15:0]);
		chk("cmd_code", 16'h00a0, {8'h00, o_command_code});
		chk("busy_cmd", 16'h1, {15'h0, o_busy});
		chk("intrq_cmd", 16'h0, {15'h0, o_intrq});
		pulse_fw(1'b0);
		wr(1'b0, `AHTF_DA_DRVSEL, 16'h00b0);
		chk("sel_off", 16'h0, {15'h0, o_selected});
		chk("intrq_off", 16'h1, {15'h0, o_intrq_oe_b});
		wr(1'b0, `AHTF_DA_CMD_STAT, 16'h00a0);
		chk("n_cmd_uns", 16'h1, n_cmd[15:0]);
		chk("busy_uns", 16'h0, {15'h0, o_busy});
		wr(1'b0, `AHTF_DA_CMD_STAT, 16'h0090);
		chk("n_cmd_diag", 16'h2, n_cmd[15:0]);
		chk("busy_diag", 16'h1, {15'h0, o_busy});
		@(posedge clk);
		remote <= 1'b1;
		repeat (3) @(posedge clk);
		chk("sel_remote", 16'h1, {15'h0, o_selected});
		pulse_fw(1'b0);
		wr(1'b1, `AHTF_DA_DCTL_ALT, 16'h0006);
		chk("n_srst", 16'h1, n_srst[15:0]);
		chk("busy_srst", 16'h1, {15'h0, o_busy});
		chk("nien", 16'h1, {15'h0, o_intrq_oe_b});
		wr(1'b1, `AHTF_DA_DCTL_ALT, 16'h0000);
		chk("n_srst_low", 16'h1, n_srst[15:0]);
		@(posedge clk);
		fw_wr <= 1'b1;
		fw_idx <= `AHTF_IDX_DRVADDR;
		fw_wdata <= 8'hff;
		@(posedge clk);
		fw_wr <= 1'b0;
		rd(1'b1, `AHTF_DA_DRVADDR);
		chk("drvaddr", 16'h007f, {9'h000, rdv[6:0]});
		chk("drvaddr_oe", 16'hff80, roe);
		rd(1'b1, 3'h0);
		chk("unmapped_oe", 16'hffff, roe);
		wr(1'b0, `AHTF_DA_FEAT_ERR, 16'h003c);
		chk("features", 16'h003c, {8'h00, o_features});
		wr(1'b0, `AHTF_DA_IREASON, 16'h0002);
		rd(1'b0, `AHTF_DA_IREASON);
		chk("ireason", 16'h0002, {8'h00, rdv[7:0]});
		chk("ireason_oe", 16'hff00, roe);
		print_verdict();
	end
endmodule : tb_top

`default_nettype wire
